// File: verif/bir_router_tb_top.sv
// Self-checking bench for the interrupt router.
// Assumes the router and the source model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module bir_router_tb_top;
	import bir_pkg::*;
	logic        clk = 1'b0;      // 100 MHz
	logic        arst_n = 1'b0;   // Reset, low active
	bir_io_req_t io_req = '0;     // I/O port request
	logic [7:0]  io_rdata;        // Read data
	logic        cpu_ack = 1'b0;  // Acknowledge pulse
	logic [15:0] pci_n;           // PCI lines from model
	logic [15:0] isa_irq = '0;    // Legacy ISA pins
	logic        timer = 1'b0;    // Timer source
	logic        kbd = 1'b0;      // Keyboard source
	logic [1:0]  ser = '0;        // Serial port sources
	logic [3:0]  dev_req = '0;    // On-board PCI devices
	logic [23:0] slot_req = '0;   // Slot pins
	logic [2:0]  sio_o;           // Released line values
	logic [2:0]  sio_oe;          // Released line enables
	logic        cpu_intr;        // Legacy INTR
	logic [3:0]  cpu_irq_num;     // Legacy line number
	logic        apic_valid;      // APIC request
	logic [4:0]  apic_input;      // APIC input number
	int          fails = 0;       // Mismatches
	int          check_count = 0; // Comparisons

	always #5 clk = ~clk;

	bir_src_model bir_src_model_inst (.dev_req(dev_req),
		.slot_req(slot_req), .pci_irq_input_n(pci_n));

	// RTC, FPU and parallel sources tied quiet
	bir_router bir_router_inst (.clk(clk), .arst_n(arst_n),
		.io_req(io_req), .io_rdata(io_rdata), .cpu_ack(cpu_ack),
		.pci_irq_input_n(pci_n), .isa_irq_i(isa_irq),
		.timer_irq(timer), .kbd_irq(kbd), .rtc_irq(1'b0),
		.fpu_err_irq(1'b0), .ser_irq(ser), .par_irq(1'b0),
		.sio_irq_o(sio_o), .sio_irq_oe(sio_oe), .cpu_intr(cpu_intr),
		.cpu_irq_num(cpu_irq_num), .apic_valid(apic_valid),
		.apic_input(apic_input));

	// Verdict and end of run
	task automatic results();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One port cycle; one idle cycle after so strobes never merge
	task automatic io(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge clk);
		io_req = '{wr: w, rd: ~w, addr: a, wdata: d};
		@(negedge clk);
		io_req = '0;
	endtask

	// Index then data byte
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		io(1'b1, BIR_IDX_ADDR, ix);
		io(1'b1, BIR_DATA_ADDR, d);
	endtask

	// Read an indexed byte and compare
	task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
		io(1'b1, BIR_IDX_ADDR, ix);
		io(1'b0, BIR_DATA_ADDR, 8'h00);
		@(negedge clk);
		`CHK(io_rdata, e)
	endtask

	// Bounded wait for a level; running out ends the run
	task automatic wait_lvl(ref logic s, input logic v);
		int n;
		for (n = 0; n < 30 && s !== v; n++)
			@(negedge clk);
		`CHK(s, v)
		if (s !== v)
			results();
	endtask

	// Acknowledge pulse, then let the request settle
	task automatic ack();
		@(negedge clk);
		cpu_ack = 1'b1;
		@(negedge clk);
		cpu_ack = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	// Reset values, refused addresses and the steering store
	task automatic t_regs();
		rdc(BIR_IX_STEER, BIR_RST_STEER);
		rdc(BIR_IX_MASK0, 8'h01);
		rdc(BIR_IX_MODE, 8'h00);
		rdc(8'h40, 8'h00);
		wr(8'h0F, 8'h8D);
		rdc(8'h0F, 8'h0D);
		wr(8'h0F, 8'h8F);
		rdc(8'h0F, 8'h8F);
		// Foreign address must overwrite the nonzero read data
		io(1'b0, 16'h0C02, 8'h00);
		@(negedge clk);
		`CHK(io_rdata, 8'h00)
	endtask

	// Serial port 1: level survives an acknowledge, edge does not
	task automatic t_ser();
		wr(BIR_IX_SIO, 8'h17);
		wr(BIR_IX_IMRL, 8'hEF);
		ser[0] = 1'b1;
		wait_lvl(cpu_intr, 1'b1);
		`CHK(cpu_irq_num, BIR_LN_SER1)
		`CHK(sio_o, 3'b001)
		ack();
		`CHK(cpu_intr, 1'b1)
		wr(BIR_IX_SIO, 8'h13);
		ack();
		`CHK(cpu_intr, 1'b0)
		ser[0] = 1'b0;
		wr(BIR_IX_IMRL, 8'hFF);
	endtask

	// Fixed legacy lines and priority across an acknowledge
	task automatic t_legacy();
		wr(BIR_IX_IMRL, 8'hFC);
		timer = 1'b1;
		kbd = 1'b1;
		wait_lvl(cpu_intr, 1'b1);
		`CHK(cpu_irq_num, BIR_LN_TIMER)
		ack();
		`CHK(cpu_irq_num, BIR_LN_KBD)
		ack();
		`CHK(cpu_intr, 1'b0)
		timer = 1'b0;
		kbd = 1'b0;
	endtask

	// Shared line steered into the PICs, then switched off by clearing its APIC mask
	task automatic t_steer();
		wr(8'h0B, 8'h8A);
		wr(BIR_IX_IMRL, 8'hFB);
		wr(BIR_IX_IMRH, 8'hFB);
		slot_req[1] = 1'b1;
		slot_req[5] = 1'b1;
		wait_lvl(cpu_intr, 1'b1);
		`CHK(cpu_irq_num, 4'hA)
		slot_req[1] = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(cpu_intr, 1'b1)
		wr(8'h1B, 8'h00);
		wait_lvl(cpu_intr, 1'b0);
		wr(8'h1B, 8'h01);
		wait_lvl(cpu_intr, 1'b1);
		slot_req[5] = 1'b0;
		wait_lvl(cpu_intr, 1'b0);
	endtask

	// Symmetric delivery, both APICs
	task automatic t_sym();
		wr(BIR_IX_MODE, 8'h02);
		wr(BIR_IX_MASK0, 8'h00);
		dev_req[0] = 1'b1;
		wait_lvl(apic_valid, 1'b1);
		`CHK(apic_input, 5'h10)
		`CHK(cpu_intr, 1'b0)
		dev_req[0] = 1'b0;
		wait_lvl(apic_valid, 1'b0);
		isa_irq[5] = 1'b1;
		wr(8'h25, 8'h00);
		repeat (8) @(negedge clk);
		`CHK(apic_valid, 1'b0)
		wr(BIR_IX_MODE, 8'h06);
		wait_lvl(apic_valid, 1'b1);
		`CHK(apic_input, 5'h05)
		isa_irq[5] = 1'b0;
	endtask

	// Ports release their lines until enabled
	task automatic t_sio();
		`CHK(sio_oe, 3'b000)
		wr(BIR_IX_SIO, 8'h13);
		repeat (2) @(negedge clk);
		`CHK(sio_oe, 3'b111)
	endtask

	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		repeat (5) @(negedge clk);
		t_regs();
		t_sio();
		t_ser();
		t_legacy();
		t_steer();
		t_sym();
		results();
	end
endmodule
`default_nettype wire

// File: verif/bir_src_model.sv
// Far-side model: PCI devices and slot pins onto the sixteen PCI lines.
// Assumes active-high requests from the bench; lines are open drain.
`timescale 1ns/1ps
`default_nettype none
module bir_src_model (
	input  wire logic [3:0]  dev_req,
	input  wire logic [23:0] slot_req,
	output logic      [15:0] pci_irq_input_n
);
	// Slot pin index: (slot-1)*4 + pin, pin A=0 .. D=3
	logic [15:0] pull; // Any source pulling the line low

	// Wire-OR of every source except slot pins 15, 17 and 22; undriven lines rest high on pull-ups
	always_comb begin
		pull        = '0;
		pull[3:0]   = dev_req;
		pull[4]     = slot_req[4];
		pull[5]     = slot_req[8];
		pull[7]     = slot_req[12];
		pull[8]     = slot_req[16];
		pull[9]     = slot_req[20];
		pull[10]    = slot_req[0];
		pull[11]    = |{slot_req[1], slot_req[5], slot_req[10],
			slot_req[13], slot_req[18], slot_req[23]};
		pull[12]    = |{slot_req[2], slot_req[6], slot_req[11],
			slot_req[14], slot_req[19], slot_req[21]};
		pull[13]    = |{slot_req[3], slot_req[7], slot_req[9],
			slot_req[14], slot_req[19], slot_req[21]};
		pci_irq_input_n = ~pull;
	end
endmodule
`default_nettype wire

// File: verilog/bir_apic.sv
// One I/O APIC: masked level inputs, lowest-numbered pending request.
// Assumes inputs are already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module bir_apic
	import bir_pkg::*;
#(
	parameter  int N  = 16,
	localparam int IW = $clog2(N)
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          en,
	input  wire logic [N-1:0]  line,
	input  wire logic [N-1:0]  mask,
	output logic               valid,
	output logic      [IW-1:0] idx,
	output logic      [N-1:0]  pend
);
	logic [N-1:0]  pend_nxt;  // Masked requests
	logic          valid_nxt; // Any request
	logic [IW-1:0] idx_nxt;   // Winning entry

	// Disabled unit raises nothing; lower entry number wins
	always_comb begin
		pend_nxt  = en ? (line & ~mask) : '0;
		valid_nxt = |pend_nxt;
		idx_nxt   = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (pend_nxt[k]) begin
				idx_nxt = IW'(k);
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend  <= '0;
			valid <= 1'b0;
			idx   <= '0;
		end else begin
			pend  <= pend_nxt;
			valid <= valid_nxt;
			idx   <= idx_nxt;
		end
	end

	// Unmasked active input 0 shows as pending next cycle
	chk_apic_mask_pass: assert property (@(posedge clk) disable iff (!rst_n)
		en && line[0] && !mask[0] |=> pend[0] && valid)
		else $error("unmasked APIC input not pending");
endmodule
`default_nettype wire

// File: verilog/bir_pkg.sv
// Shared constants and types of the board interrupt router.
// Assumes a single 100 MHz clock domain and the 8-bit I/O index port.
package bir_pkg;

	// I/O port: steering index register and its data window
	localparam logic [15:0] BIR_IDX_ADDR  = 16'h0C00;
	localparam logic [15:0] BIR_DATA_ADDR = 16'h0C01;

	// Index map behind the data window
	localparam logic [7:0] BIR_IX_STEER = 8'h00; // 16 steering entries
	localparam logic [7:0] BIR_IX_MASK0 = 8'h10; // PCI APIC masks
	localparam logic [7:0] BIR_IX_MASK1 = 8'h20; // ISA APIC masks
	localparam logic [7:0] BIR_IX_MODE  = 8'h30;
	localparam logic [7:0] BIR_IX_SIO   = 8'h31;
	localparam logic [7:0] BIR_IX_IMRL  = 8'h32;
	localparam logic [7:0] BIR_IX_IMRH  = 8'h33;
	localparam logic [7:0] BIR_IX_IRRL  = 8'h34; // read only
	localparam logic [7:0] BIR_IX_IRRH  = 8'h35; // read only

	// Values after reset
	localparam logic [7:0]  BIR_RST_INDEX = 8'h00;
	localparam logic [7:0]  BIR_RST_STEER = 8'h00;
	localparam logic [15:0] BIR_RST_MASK  = 16'hFFFF;
	localparam logic [15:0] BIR_RST_IMR   = 16'hFFFF;

	// Legacy lines a PCI input may be steered to (3-7, 9-12, 14, 15)
	localparam logic [15:0] BIR_STEER_OK = 16'hDEF8;
	localparam int          BIR_STEER_EN = 7;

	// Fixed legacy line numbers
	localparam logic [3:0] BIR_LN_TIMER = 4'h0;
	localparam logic [3:0] BIR_LN_KBD   = 4'h1;
	localparam logic [3:0] BIR_LN_CASC  = 4'h2;
	localparam logic [3:0] BIR_LN_SER2  = 4'h3;
	localparam logic [3:0] BIR_LN_SER1  = 4'h4;
	localparam logic [3:0] BIR_LN_PAR   = 4'h7;
	localparam logic [3:0] BIR_LN_RTC   = 4'h8;
	localparam logic [3:0] BIR_LN_FPU   = 4'hD;
	localparam logic [3:0] BIR_LN_NONE  = 4'hF;

	// Delivery modes
	typedef enum logic [1:0] {
		BIR_PIC,
		BIR_VWIRE,
		BIR_SYM
	} bir_mode_t;

	// Mode register layout
	typedef struct packed {
		logic      ext_apic;
		bir_mode_t mode;
	} bir_cfg_t;

	// Serial/parallel port configuration layout
	typedef struct packed {
		logic       par_en;
		logic [1:0] ser_lvl;
		logic [1:0] ser_en;
	} bir_sio_t;

	// I/O port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bir_io_req_t;

	localparam bir_cfg_t BIR_RST_CFG = '{ext_apic: 1'b0, mode: BIR_PIC};
	localparam bir_sio_t BIR_RST_SIO = '0;

endpackage

// File: verilog/bir_router.sv
// Board interrupt router: two cascaded legacy PICs, two I/O APICs,
// PCI-to-legacy steering and serial/parallel line release.
// Assumes pins are asynchronous; I/O port and acks are on clk.
`timescale 1ns/1ps
`default_nettype none
module bir_router
	import bir_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire bir_io_req_t io_req,
	output logic      [7:0]  io_rdata,
	input  wire logic        cpu_ack,
	input  wire logic [15:0] pci_irq_input_n,
	input  wire logic [15:0] isa_irq_i,
	input  wire logic        timer_irq,
	input  wire logic        kbd_irq,
	input  wire logic        rtc_irq,
	input  wire logic        fpu_err_irq,
	input  wire logic [1:0]  ser_irq,
	input  wire logic        par_irq,
	output logic      [2:0]  sio_irq_o,
	output logic      [2:0]  sio_irq_oe,
	output logic             cpu_intr,
	output logic      [3:0]  cpu_irq_num,
	output logic             apic_valid,
	output logic      [4:0]  apic_input
);
	localparam int SW = 39; // Width of the pin synchroniser

	logic          rst_n;       // Synchronised reset
	logic [SW-1:0] pins_s;      // Synchronised pins
	logic [15:0]   pci_lvl;     // PCI request, active high
	logic [15:0]   isa_s;       // ISA pins
	logic          timer_s;
	logic          kbd_s;
	logic          rtc_s;
	logic          fpu_s;
	logic [1:0]    ser_s;
	logic          par_s;

	logic [7:0]  index_r;          // pci_irq_steer_index
	logic [7:0]  index_nxt;
	logic [7:0]  steer_r [16];     // Steering entries
	logic [7:0]  steer_nxt [16];
	logic [15:0] mask0_r;          // PCI APIC masks, 1 = masked
	logic [15:0] mask0_nxt;
	logic [15:0] mask1_r;          // ISA APIC masks
	logic [15:0] mask1_nxt;
	bir_cfg_t    cfg_r;
	bir_cfg_t    cfg_nxt;
	bir_sio_t    sio_r;
	bir_sio_t    sio_nxt;
	logic [15:0] imr_r;            // PIC interrupt masks
	logic [15:0] imr_nxt;
	logic [7:0]  rdata_nxt;

	logic [15:0] steer_hit [16];   // One-hot target per PCI input
	logic [15:0] lines;            // Legacy lines into the PICs
	logic [15:0] elcr;             // 1 = level triggered line
	logic [15:0] lines_prev_r;
	logic [15:0] irr_r;            // PIC request latches
	logic [15:0] irr_nxt;
	logic [15:0] req;
	logic        intr_nxt;
	logic [3:0]  num_nxt;
	logic [2:0]  sio_o_nxt;
	logic [2:0]  sio_oe_nxt;
	logic        a0_valid;
	logic [3:0]  a0_idx;
	logic        a1_valid;
	logic [3:0]  a1_idx;
	logic        apic_valid_nxt;
	logic [4:0]  apic_input_nxt;
	logic        wr_data;          // Write into the data window
	logic [7:0]  wd;

	// Reset release through two flops
	bir_sync #(.W(1)) u_rst_sync (
		.clk   (clk),
		.rst_n (arst_n),
		.d     (1'b1),
		.q     (rst_n)
	);

	// Every pin passes two flops before use
	bir_sync #(.W(SW)) u_pin_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({~pci_irq_input_n, isa_irq_i, timer_irq, kbd_irq,
		         rtc_irq, fpu_err_irq, ser_irq, par_irq}),
		.q     (pins_s)
	);

	// Shared wire-OR lines: low pin means someone asks, held as level
	assign pci_lvl = pins_s[38:23];
	assign isa_s   = pins_s[22:7];
	assign timer_s = pins_s[6];
	assign kbd_s   = pins_s[5];
	assign rtc_s   = pins_s[4];
	assign fpu_s   = pins_s[3];
	assign ser_s   = pins_s[2:1];
	assign par_s   = pins_s[0];

	assign wr_data = io_req.wr && (io_req.addr == BIR_DATA_ADDR);
	assign wd      = io_req.wdata;

	// Steering decode per PCI input
	for (genvar i = 0; i < 16; i++) begin : g_steer
		logic act;
		// Active only while the APIC entry is masked
		assign act = steer_r[i][BIR_STEER_EN] && mask0_r[i];
		assign steer_hit[i] = act ? (16'h0001 << steer_r[i][3:0])
		                          : 16'h0000;
	end

	// Register file behind the index/data port
	always_comb begin
		index_nxt = index_r;
		steer_nxt = steer_r;
		mask0_nxt = mask0_r;
		mask1_nxt = mask1_r;
		cfg_nxt   = cfg_r;
		sio_nxt   = sio_r;
		imr_nxt   = imr_r;
		if (io_req.wr && io_req.addr == BIR_IDX_ADDR) begin
			index_nxt = wd;
		end else if (wr_data && index_r[7:4] == BIR_IX_STEER[7:4]) begin
			// Targets outside the eleven lines are stored disabled
			steer_nxt[index_r[3:0]] = {wd[7] && BIR_STEER_OK[wd[3:0]],
			                           3'h0, wd[3:0]};
		end else if (wr_data && index_r[7:4] == BIR_IX_MASK0[7:4]) begin
			mask0_nxt[index_r[3:0]] = wd[0];
		end else if (wr_data && index_r[7:4] == BIR_IX_MASK1[7:4]) begin
			mask1_nxt[index_r[3:0]] = wd[0];
		end else if (wr_data && index_r == BIR_IX_MODE) begin
			cfg_nxt.ext_apic = wd[2];
			// Undefined code falls back to PIC mode
			cfg_nxt.mode = (wd[1:0] == 2'b11) ? BIR_PIC
			                                  : bir_mode_t'(wd[1:0]);
		end else if (wr_data && index_r == BIR_IX_SIO) begin
			sio_nxt = bir_sio_t'(wd[4:0]);
		end else if (wr_data && index_r == BIR_IX_IMRL) begin
			imr_nxt[7:0] = wd;
		end else if (wr_data && index_r == BIR_IX_IMRH) begin
			imr_nxt[15:8] = wd;
		end
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		rdata_nxt = io_rdata;
		if (io_req.rd && io_req.addr == BIR_IDX_ADDR) begin
			rdata_nxt = index_r;
		end else if (io_req.rd && io_req.addr == BIR_DATA_ADDR) begin
			if (index_r[7:4] == BIR_IX_STEER[7:4]) begin
				rdata_nxt = steer_r[index_r[3:0]];
			end else if (index_r[7:4] == BIR_IX_MASK0[7:4]) begin
				rdata_nxt = {7'h00, mask0_r[index_r[3:0]]};
			end else if (index_r[7:4] == BIR_IX_MASK1[7:4]) begin
				rdata_nxt = {7'h00, mask1_r[index_r[3:0]]};
			end else if (index_r == BIR_IX_MODE) begin
				rdata_nxt = {5'h00, cfg_r};
			end else if (index_r == BIR_IX_SIO) begin
				rdata_nxt = {3'h0, sio_r};
			end else if (index_r == BIR_IX_IMRL) begin
				rdata_nxt = imr_r[7:0];
			end else if (index_r == BIR_IX_IMRH) begin
				rdata_nxt = imr_r[15:8];
			end else if (index_r == BIR_IX_IRRL) begin
				rdata_nxt = irr_r[7:0];
			end else if (index_r == BIR_IX_IRRH) begin
				rdata_nxt = irr_r[15:8];
			end else begin
				rdata_nxt = 8'h00;
			end
		end else if (io_req.rd) begin
			rdata_nxt = 8'h00;
		end
	end

	// Register file and read data flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			index_r  <= BIR_RST_INDEX;
			steer_r  <= '{default: BIR_RST_STEER};
			mask0_r  <= BIR_RST_MASK;
			mask1_r  <= BIR_RST_MASK;
			cfg_r    <= BIR_RST_CFG;
			sio_r    <= BIR_RST_SIO;
			imr_r    <= BIR_RST_IMR;
			io_rdata <= 8'h00;
		end else begin
			index_r  <= index_nxt;
			steer_r  <= steer_nxt;
			mask0_r  <= mask0_nxt;
			mask1_r  <= mask1_nxt;
			cfg_r    <= cfg_nxt;
			sio_r    <= sio_nxt;
			imr_r    <= imr_nxt;
			io_rdata <= rdata_nxt;
		end
	end

	// Serial and parallel drivers; disabled port lets the card drive
	always_comb begin
		sio_oe_nxt = {sio_r.par_en, sio_r.ser_en};
		sio_o_nxt  = {par_s, ser_s};
	end

	// Legacy line assembly and trigger selection
	always_comb begin
		// Released serial/parallel lines come from the pin instead
		lines = isa_s;
		lines[BIR_LN_SER2] = sio_irq_oe[1] ? sio_irq_o[1] : isa_s[3];
		lines[BIR_LN_SER1] = sio_irq_oe[0] ? sio_irq_o[0] : isa_s[4];
		lines[BIR_LN_PAR]  = sio_irq_oe[2] ? sio_irq_o[2] : isa_s[7];
		lines[BIR_LN_TIMER] = timer_s;
		lines[BIR_LN_KBD]   = kbd_s;
		lines[BIR_LN_CASC]  = 1'b0;
		lines[BIR_LN_RTC]   = rtc_s;
		lines[BIR_LN_FPU]   = fpu_s;
		lines[BIR_LN_NONE]  = 1'b0;
		elcr = 16'h0000;
		// Serial trigger selectable per enabled port
		elcr[BIR_LN_SER1] = sio_r.ser_en[0] && sio_r.ser_lvl[0];
		elcr[BIR_LN_SER2] = sio_r.ser_en[1] && sio_r.ser_lvl[1];
		// Steered PCI requests OR in and are level
		for (int i = 0; i < 16; i++) begin
			lines = lines | (steer_hit[i] & {16{pci_lvl[i]}});
			elcr  = elcr | steer_hit[i];
		end
	end

	// Legacy PIC pair: slave rides on master line 2
	always_comb begin
		// Edge latch; a new edge beats the acknowledge clear
		irr_nxt = (irr_r & ~(cpu_ack && cpu_intr ?
		           (16'h0001 << cpu_irq_num) : 16'h0000))
		          | (lines & ~lines_prev_r);
		// Request gone before service is dropped, so a line that
		// leaves level mode cannot stay latched forever
		irr_nxt = irr_nxt & lines;
		irr_nxt = (irr_nxt & ~elcr) | (lines & elcr);
		req = irr_r & ~imr_r;
		if (imr_r[BIR_LN_CASC]) begin
			req[15:8] = 8'h00;
		end
		// Order 0,1, slave 8-15, then 3-7
		num_nxt  = 4'h0;
		intr_nxt = 1'b0;
		for (int k = 14; k >= 0; k--) begin
			if (req[k < 2 ? k : (k < 10 ? k + 6 : k - 7)]) begin
				num_nxt  = 4'(k < 2 ? k : (k < 10 ? k + 6 : k - 7));
				intr_nxt = 1'b1;
			end
		end
		// PIC and virtual wire both use the INTR path
		intr_nxt = intr_nxt && (cfg_r.mode != BIR_SYM);
	end

	// Default APIC: PCI inputs, symmetric mode only
	bir_apic #(.N(16)) u_apic_pci (
		.clk   (clk),
		.rst_n (rst_n),
		.en    (cfg_r.mode == BIR_SYM),
		.line  (pci_lvl),
		.mask  (mask0_r),
		.valid (a0_valid),
		.idx   (a0_idx),
		.pend  ()
	);

	// Extended APIC: legacy lines, only when selected
	bir_apic #(.N(16)) u_apic_isa (
		.clk   (clk),
		.rst_n (rst_n),
		.en    (cfg_r.mode == BIR_SYM && cfg_r.ext_apic),
		.line  (lines),
		.mask  (mask1_r),
		.valid (a1_valid),
		.idx   (a1_idx),
		.pend  ()
	);

	// Lower APIC input wins; PCI sits at 16-31
	always_comb begin
		apic_valid_nxt = a1_valid || a0_valid;
		apic_input_nxt = a1_valid ? {1'b0, a1_idx}
		                          : {a0_valid, a0_idx};
	end

	// PIC, driver and APIC output flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irr_r        <= 16'h0000;
			lines_prev_r <= 16'h0000;
			cpu_intr     <= 1'b0;
			cpu_irq_num  <= 4'h0;
			sio_irq_o    <= 3'h0;
			sio_irq_oe   <= 3'h0;
			apic_valid   <= 1'b0;
			apic_input   <= 5'h00;
		end else begin
			irr_r        <= irr_nxt;
			lines_prev_r <= lines;
			cpu_intr     <= intr_nxt;
			cpu_irq_num  <= num_nxt;
			sio_irq_o    <= sio_o_nxt;
			sio_irq_oe   <= sio_oe_nxt;
			apic_valid   <= apic_valid_nxt;
			apic_input   <= apic_input_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// PCI entry 0 held up in symmetric mode
	sequence s_pci0_sym;
		cfg_r.mode == BIR_SYM && !cfg_r.ext_apic
		&& pci_lvl[0] && !mask0_r[0];
	endsequence

	chk_sym_no_intr: assert property (
		cfg_r.mode == BIR_SYM |=> !cpu_intr)
		else $error("INTR raised in symmetric mode");
	chk_pci_base_16: assert property (
		s_pci0_sym [*3] |-> apic_valid && apic_input == 5'h10)
		else $error("PCI line 0 not at APIC input 16");
	chk_ext_apic_gate: assert property (
		apic_valid && !apic_input[4] |-> $past(cfg_r.ext_apic, 2))
		else $error("ISA APIC active while not extended");
	chk_steer_range: assert property (
		wr_data && index_r < 8'h10 && !BIR_STEER_OK[wd[3:0]]
		|=> !steer_r[$past(index_r[3:0])][BIR_STEER_EN])
		else $error("steering to illegal line accepted");
	chk_steer_mask: assert property (
		!mask0_r[0] && steer_r[0][BIR_STEER_EN]
		|-> steer_hit[0] == 16'h0000)
		else $error("steering active with APIC entry unmasked");
	chk_timer_line: assert property (
		$rose(timer_s) |=> irr_r[BIR_LN_TIMER])
		else $error("timer edge not latched on line 0");
	chk_cascade_mask: assert property (
		imr_r[BIR_LN_CASC] |=> !(cpu_intr && cpu_irq_num[3]))
		else $error("slave request passed masked cascade");
	chk_ser_release: assert property (
		!sio_r.ser_en[0] ##1 !sio_r.ser_en[0] |-> !sio_irq_oe[0])
		else $error("disabled serial port still drives");
	chk_par_release: assert property (
		!sio_r.par_en |=> !sio_irq_oe[2])
		else $error("disabled parallel port still drives");
	chk_ser_trigger: assert property (
		sio_r.ser_en[0] && sio_r.ser_lvl[0] && ser_s[0] && sio_irq_oe[0]
		&& sio_irq_o[0] |=> irr_r[BIR_LN_SER1])
		else $error("level serial request not held");
endmodule
`default_nettype wire

// File: verilog/bir_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes rst_n may be released out of step with clk, as arst_n is.
`timescale 1ns/1ps
`default_nettype none
module bir_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r; // First stage, read only by q

	// Plain shift; metastability settles in meta_r
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire
